/* src/spf_framer.sv */
// Purpose: builds the 26-byte status packets one, two, three in a cycle
// Assumes: status inputs come from logic on core_clk; body bytes are
//          looked up outside from body_pkt_q and body_idx_q in the same cycle
// Notes:   header bytes are frozen at the start of each packet
`timescale 1ns/1ps
`include "spf_defs.svh"
module spf_framer
  import spf_pkg::*;
#(
  parameter int FIFO_DEPTH = `SPF_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // control
  input  wire logic       framer_enable,
  // operating state
  input  wire logic       hours_reset,
  input  wire logic       system_on,
  input  wire logic       tec_shutdown,
  input  wire logic       reboot_triggered,
  input  wire logic       data_saved,
  input  wire logic       control_port_on_signal,
  // operating mode
  input  wire logic       serial_control,
  input  wire logic       remote_mode,
  input  wire logic       serial_data_received,
  // data sources
  input  wire logic [1:0] limit_src,
  input  wire logic [2:0] setpoint_src,
  input  wire logic [2:0] temp_src,
  input  wire logic [7:0] io_control_byte,
  // packet body lookup
  output logic [1:0]      body_pkt_q,
  output logic [4:0]      body_idx_q,
  input  wire logic [7:0] body_byte,
  // serial transmitter side
  output logic [7:0]      tx_data_q,
  output logic            tx_valid_q,
  input  wire logic       tx_ready,
  // status
  output logic            decoder_fault_flag_q,
  output logic            busy_q
);
  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("spf_framer: fifo depth too small");
  end

  ////////////////////////////////////////////////////////////////////////////
  // snapshot of the header
  logic [7:0] operating_state_byte_q, operating_state_byte_d;
  logic [7:0] operating_mode_byte_q, operating_mode_byte_d;
  logic [7:0] source_decoder_byte_q, source_decoder_byte_d;
  logic [7:0] ioc_q, ioc_d;
  logic [7:0] live_state, live_mode, live_dec;
  logic       fault_d;

  always_comb begin
    live_state = 8'h00;
    live_state[`SPF_ST_HOURS_RST] = hours_reset;
    live_state[`SPF_ST_ON]        = system_on;
    live_state[`SPF_ST_TEC_SD]    = tec_shutdown;
    live_state[`SPF_ST_REBOOT]    = reboot_triggered;
    live_state[`SPF_ST_SAVED]     = data_saved;
    live_state[`SPF_ST_PORT_ON]   = control_port_on_signal;
    live_mode = 8'h00;
    live_mode[`SPF_OM_SERIAL]  = serial_control;
    live_mode[`SPF_OM_REMOTE]  = remote_mode;
    live_mode[`SPF_OM_TEC_SD]  = tec_shutdown;
    live_mode[`SPF_OM_RX_DATA] = serial_data_received;
    live_dec = {temp_src, setpoint_src, limit_src};
    // codes outside the defined set are still passed on so software can see them
    fault_d = (limit_src != `SPF_SRC2_SERIAL && limit_src != `SPF_SRC2_MEMORY
               && limit_src != `SPF_SRC2_PORT)
           || (setpoint_src != `SPF_SRC3_SERIAL && setpoint_src != `SPF_SRC3_MEMORY
               && setpoint_src != `SPF_SRC3_PORT && setpoint_src != `SPF_SRC3_PANEL)
           || (temp_src != `SPF_SRC3_SERIAL && temp_src != `SPF_SRC3_MEMORY
               && temp_src != `SPF_SRC3_PORT && temp_src != `SPF_SRC3_PANEL);
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  spf_state_t st_q, st_d;
  logic [4:0] idx_q, idx_d;
  logic [1:0] pkt_q, pkt_d;
  logic       busy_d;
  logic [7:0] byte_mux;
  logic       push, fifo_in_ready, fifo_empty;

  always_comb begin
    if (idx_q <= `SPF_IDX_START2) begin
      byte_mux = `SPF_START_BYTE;
    end else if (idx_q == `SPF_IDX_STATE) begin
      byte_mux = operating_state_byte_q;
    end else if (idx_q == `SPF_IDX_MODE) begin
      byte_mux = operating_mode_byte_q;
    end else if (idx_q == `SPF_IDX_DEC) begin
      byte_mux = source_decoder_byte_q;
    end else if (idx_q == `SPF_IDX_IOC) begin
      byte_mux = ioc_q;
    end else begin
      byte_mux = body_byte;
    end
  end

  assign push = (st_q == SPF_EMIT) && fifo_in_ready;

  always_comb begin
    st_d                   = st_q;
    idx_d                  = idx_q;
    pkt_d                  = pkt_q;
    operating_state_byte_d = operating_state_byte_q;
    operating_mode_byte_d  = operating_mode_byte_q;
    source_decoder_byte_d  = source_decoder_byte_q;
    ioc_d                  = ioc_q;
    case (st_q)
      SPF_IDLE: begin
        if (framer_enable && fifo_empty) begin
          st_d = SPF_SNAP;
        end
      end
      SPF_SNAP: begin
        operating_state_byte_d = live_state;
        operating_mode_byte_d  = live_mode;
        source_decoder_byte_d  = live_dec;
        ioc_d                  = io_control_byte;
        idx_d                  = 5'd0;
        st_d                   = SPF_EMIT;
      end
      SPF_EMIT: begin
        if (push) begin
          if (idx_q == `SPF_LAST_IDX) begin
            st_d = SPF_DRAIN;
          end else begin
            idx_d = idx_q + 5'd1;
          end
        end
      end
      SPF_DRAIN: begin
        // wait until the transmitter has taken every byte of this packet
        if (fifo_empty) begin
          st_d  = SPF_IDLE;
          idx_d = 5'd0;
          pkt_d = (pkt_q == SPF_PKT_THREE) ? SPF_PKT_ONE : pkt_q + 2'd1;
        end
      end
      default: begin
        st_d = SPF_IDLE;
      end
    endcase
    busy_d = (st_d != SPF_IDLE);
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_q                   <= SPF_IDLE;
      idx_q                  <= 5'd0;
      pkt_q                  <= SPF_PKT_ONE;
      operating_state_byte_q <= 8'h00;
      operating_mode_byte_q  <= 8'h00;
      source_decoder_byte_q  <= 8'h00;
      ioc_q                  <= 8'h00;
      decoder_fault_flag_q   <= 1'b0;
      busy_q                 <= 1'b0;
      body_idx_q             <= 5'd0;
      body_pkt_q             <= SPF_PKT_ONE;
    end else begin
      st_q                   <= st_d;
      idx_q                  <= idx_d;
      pkt_q                  <= pkt_d;
      operating_state_byte_q <= operating_state_byte_d;
      operating_mode_byte_q  <= operating_mode_byte_d;
      source_decoder_byte_q  <= source_decoder_byte_d;
      ioc_q                  <= ioc_d;
      decoder_fault_flag_q   <= fault_d;
      busy_q                 <= busy_d;
      body_idx_q             <= idx_d;
      body_pkt_q             <= pkt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output buffer
  spf_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk    (core_clk),
    .rstn        (rstn),
    .in_valid    (st_q == SPF_EMIT),
    .in_data     (byte_mux),
    .in_ready    (fifo_in_ready),
    .out_valid_q (tx_valid_q),
    .out_data_q  (tx_data_q),
    .out_ready   (tx_ready),
    .empty_all   (fifo_empty)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_START_BYTES: assert property (@(posedge core_clk) disable iff (!rstn)
    push && idx_q <= 5'd1 |-> byte_mux == 8'h0A)
    else $error("start byte wrong");
  AST_START_VALUE: assert property (@(posedge core_clk) disable iff (!rstn)
    push && idx_q == 5'd0 |-> ##[1:40] (push && idx_q == 5'd1 && byte_mux == 8'h0A))
    else $error("second start byte missing");
  AST_STATE_BYTE: assert property (@(posedge core_clk) disable iff (!rstn)
    push && idx_q == 5'd2 |-> (byte_mux & 8'h09) == 8'h00
      && byte_mux[7] == operating_state_byte_q[7])
    else $error("state byte unused bits set");
  AST_STATE_SNAP: assert property (@(posedge core_clk) disable iff (!rstn)
    st_q == SPF_SNAP |=> operating_state_byte_q == $past(live_state)
      && operating_state_byte_q[4] == $past(tec_shutdown))
    else $error("state byte not sampled");
  AST_MODE_BYTE: assert property (@(posedge core_clk) disable iff (!rstn)
    push && idx_q == 5'd3 |-> (byte_mux & 8'hA5) == 8'h00)
    else $error("mode byte unused bits set");
  AST_DEC_FIELDS: assert property (@(posedge core_clk) disable iff (!rstn)
    st_q == SPF_SNAP |=> source_decoder_byte_q[1:0] == $past(limit_src)
      && source_decoder_byte_q[4:2] == $past(setpoint_src))
    else $error("decoder fields wrong");
  AST_DEC_FAULT: assert property (@(posedge core_clk) disable iff (!rstn)
    (setpoint_src == 3'h3 || limit_src == 2'h3) |=> decoder_fault_flag_q)
    else $error("decoder fault not flagged");
  AST_LENGTH: assert property (@(posedge core_clk) disable iff (!rstn)
    push && idx_q == 5'd25 |=> st_q == SPF_DRAIN)
    else $error("packet length not 26");
  AST_NO_OVERLAP: assert property (@(posedge core_clk) disable iff (!rstn)
    st_q == SPF_SNAP |-> $past(fifo_empty))
    else $error("packet started before drain");
  AST_CYCLE: assert property (@(posedge core_clk) disable iff (!rstn)
    st_q == SPF_DRAIN && fifo_empty && pkt_q == 2'h2 |=> pkt_q == 2'h0)
    else $error("packet cycle wrong");

endmodule

/* pkg/spf_defs.svh */
// Purpose: constants of the status packet framer
// Assumes: included by the framer and its fifo
// Notes:   definitions only
`ifndef SPF_DEFS_SVH
`define SPF_DEFS_SVH

`define SPF_START_BYTE   8'h0A
`define SPF_PKT_LEN      5'd26
`define SPF_LAST_IDX     5'd25
`define SPF_IDX_START2   5'd1
`define SPF_IDX_STATE    5'd2
`define SPF_IDX_MODE     5'd3
`define SPF_IDX_DEC      5'd4
`define SPF_IDX_IOC      5'd5
// operating-state byte fields
`define SPF_ST_HOURS_RST 1
`define SPF_ST_ON        2
`define SPF_ST_TEC_SD    4
`define SPF_ST_REBOOT    5
`define SPF_ST_SAVED     6
`define SPF_ST_PORT_ON   7
// operating-mode byte fields
`define SPF_OM_SERIAL    1
`define SPF_OM_REMOTE    3
`define SPF_OM_TEC_SD    4
`define SPF_OM_RX_DATA   6
// decoder byte field positions
`define SPF_DEC_LIM_LSB  0
`define SPF_DEC_SP_LSB   2
`define SPF_DEC_TEMP_LSB 5
// legal source codes
`define SPF_SRC2_SERIAL  2'h0
`define SPF_SRC2_MEMORY  2'h1
`define SPF_SRC2_PORT    2'h2
`define SPF_SRC3_SERIAL  3'h0
`define SPF_SRC3_MEMORY  3'h1
`define SPF_SRC3_PORT    3'h2
`define SPF_SRC3_PANEL   3'h4
`define SPF_FIFO_DEPTH   16

`endif

/* pkg/spf_pkg.sv */
// Purpose: types of the status packet framer
// Assumes: nothing
// Notes:   constants live in spf_defs.svh
package spf_pkg;

  typedef enum logic [3:0] {
    SPF_IDLE  = 4'b0001,
    SPF_SNAP  = 4'b0010,
    SPF_EMIT  = 4'b0100,
    SPF_DRAIN = 4'b1000
  } spf_state_t;

  typedef enum logic [1:0] {
    SPF_PKT_ONE   = 2'h0,
    SPF_PKT_TWO   = 2'h1,
    SPF_PKT_THREE = 2'h2
  } spf_pkt_t;

endpackage

/* src/spf_fifo.sv */
// Purpose: byte fifo between framer and serial transmitter
// Assumes: single clock, synchronous active-low reset
// Notes:   read data sit in an output register, so the sink sees a flop
`timescale 1ns/1ps
`include "spf_defs.svh"
module spf_fifo
  import spf_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = `SPF_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rstn,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid_q,
  output logic [WIDTH-1:0]      out_data_q,
  input  wire logic             out_ready,
  // status
  output logic                  empty_all
);
  localparam int AW = $clog2(DEPTH);

  // pointers wrap freely, so only power-of-two depths are served
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_depth
    $error("spf_fifo: depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             ov_d;
  logic [WIDTH-1:0] od_d;
  logic             push, pop;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign push      = in_valid && in_ready;
  // pop from storage whenever the output register is free or being taken
  assign pop       = (cnt_q != '0) && (!out_valid_q || out_ready);
  assign empty_all = (cnt_q == '0) && !out_valid_q;

  always_comb begin
    wr_d  = push ? wr_q + 1'b1 : wr_q;
    rd_d  = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    ov_d  = pop ? 1'b1 : (out_ready ? 1'b0 : out_valid_q);
    od_d  = pop ? mem_q[rd_q] : out_data_q;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wr_q        <= '0;
      rd_q        <= '0;
      cnt_q       <= '0;
      out_valid_q <= 1'b0;
      out_data_q  <= '0;
    end else begin
      wr_q        <= wr_d;
      rd_q        <= rd_d;
      cnt_q       <= cnt_d;
      out_valid_q <= ov_d;
      out_data_q  <= od_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  AST_FIFO_HOLD: assert property (@(posedge core_clk) disable iff (!rstn)
    out_valid_q && !out_ready |=> out_valid_q && $stable(out_data_q))
    else $error("fifo output changed while stalled");
  AST_FIFO_CNT: assert property (@(posedge core_clk) disable iff (!rstn)
    cnt_q <= DEPTH[AW:0])
    else $error("fifo count beyond depth");

endmodule

/* tb/spf_host_model.sv */
// Purpose: host side that takes the status byte stream from the framer
// Assumes: one byte taken on each edge with tx_valid_q and tx_ready high
// Notes:   stall holds ready low 40 of every 64 cycles so the fifo fills up
`timescale 1ns/1ps
module spf_host_model (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // byte stream from the framer
  input  wire logic [7:0] tx_data_q,
  input  wire logic       tx_valid_q,
  output logic            tx_ready,
  // test control
  input  wire logic       stall
);
  logic [7:0] rx_q[$];
  logic [5:0] tick_q;

  // a slow host, not a kind one: long stalls in mid-packet
  always @(posedge core_clk) begin
    if (!rstn) begin
      tick_q   <= 6'h00;
      tx_ready <= 1'b0;
    end else begin
      tick_q <= tick_q + 6'h01;
      if (tx_valid_q && tx_ready) begin
        rx_q.push_back(tx_data_q);
      end
      tx_ready <= !stall || (tick_q >= 6'h28);
    end
  end
endmodule

/* tb/testbench.sv */
// Purpose: self-checking bench of the status packet framer
// Assumes: body bytes are looked up from packet number and index
// Notes:   inputs are scrambled in mid-packet to show the header is frozen
`timescale 1ns/1ps
module testbench;
  logic       core_clk = 1'b0;
  logic       rstn = 1'b0;
  logic       framer_enable = 1'b0;
  logic [7:0] st_in = 8'h00;
  logic [1:0] limit_src = 2'h0;
  logic [2:0] setpoint_src = 3'h0;
  logic [2:0] temp_src = 3'h0;
  logic [7:0] io_control_byte = 8'h00;
  logic [1:0] body_pkt_q;
  logic [4:0] body_idx_q;
  logic [7:0] body_byte;
  logic [7:0] tx_data_q;
  logic       tx_valid_q;
  logic       tx_ready;
  logic       decoder_fault_flag_q;
  logic       busy_q;
  logic       stall = 1'b0;
  logic [31:0] seed = 32'h0000_001F;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [7:0] e_st, e_md, e_dc, e_io;

  assign body_byte = {1'b1, body_pkt_q, body_idx_q};

  spf_framer i_dut (
    .core_clk(core_clk), .rstn(rstn), .framer_enable(framer_enable),
    .hours_reset(st_in[0]), .system_on(st_in[1]), .tec_shutdown(st_in[2]),
    .reboot_triggered(st_in[3]), .data_saved(st_in[4]),
    .control_port_on_signal(st_in[5]), .serial_control(st_in[6]),
    .remote_mode(st_in[7]), .serial_data_received(io_control_byte[0]),
    .limit_src(limit_src), .setpoint_src(setpoint_src), .temp_src(temp_src),
    .io_control_byte(io_control_byte), .body_pkt_q(body_pkt_q),
    .body_idx_q(body_idx_q), .body_byte(body_byte), .tx_data_q(tx_data_q),
    .tx_valid_q(tx_valid_q), .tx_ready(tx_ready),
    .decoder_fault_flag_q(decoder_fault_flag_q), .busy_q(busy_q));

  spf_host_model i_host (
    .core_clk(core_clk), .rstn(rstn), .tx_data_q(tx_data_q),
    .tx_valid_q(tx_valid_q), .tx_ready(tx_ready), .stall(stall));

  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // new random levels, then the fault flag after its one-cycle lag
  task automatic scramble();
    logic [31:0] r;
    logic        bad;
    r = rnd();
    @(posedge core_clk);
    st_in <= r[7:0];
    io_control_byte <= r[15:8];
    limit_src <= r[17:16];
    setpoint_src <= r[20:18];
    temp_src <= r[23:21];
    e_st = {r[5], r[4], r[3], r[2], 1'b0, r[1], r[0], 1'b0};
    e_md = {1'b0, r[8], 1'b0, r[2], r[7], 1'b0, r[6], 1'b0};
    e_dc = r[23:16];
    e_io = r[15:8];
    bad = (r[17:16] == 2'h3) || !(r[20:18] inside {3'h0, 3'h1, 3'h2, 3'h4})
          || !(r[23:21] inside {3'h0, 3'h1, 3'h2, 3'h4});
    repeat (2) @(negedge core_clk);
    chk_flag(decoder_fault_flag_q, bad);
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] s_st, s_md, s_dc, s_io, b;
    int k;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    @(negedge core_clk);
    chk_flag(tx_valid_q, 1'b0);
    chk_flag(busy_q, 1'b0);
    for (int p = 0; p < 9; p++) begin
      scramble();
      s_st = e_st;
      s_md = e_md;
      s_dc = e_dc;
      s_io = e_io;
      @(posedge core_clk);
      stall <= p[0];
      framer_enable <= 1'b1;
      k = 0;
      do begin
        @(negedge core_clk);
        k++;
      end while (busy_q !== 1'b1 && k < 100);
      @(posedge core_clk);
      framer_enable <= 1'b0;
      // header must not follow levels that change after the snapshot
      scramble();
      k = 0;
      while (i_host.rx_q.size() < 26 && k < 3000) begin
        @(negedge core_clk);
        k++;
      end
      repeat (8) @(negedge core_clk);
      chk_flag(i_host.rx_q.size() == 26, 1'b1);
      for (int i = 0; i < 26 && i_host.rx_q.size() > 0; i++) begin
        b = i_host.rx_q.pop_front();
        case (i)
          0, 1: chk_byte(b, 8'h0A);
          2: chk_byte(b, s_st);
          3: chk_byte(b, s_md);
          4: chk_byte(b, s_dc);
          5: chk_byte(b, s_io);
          default: chk_byte(b, {1'b1, 2'(p % 3), 5'(i)});
        endcase
      end
      i_host.rx_q.delete();
    end
    results();
  end
endmodule
